// >>> include/uart_pkg.sv
package uart_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h098;
  localparam logic [9:0] IDX_SERIAL_DATA_BUFFER = 10'h099;
  localparam logic [9:0] IDX_UART_CONFIG = 10'h0A0;

  // Serial control bit positions
  localparam int unsigned SC_MODE_HIGH = 7;
  localparam int unsigned SC_MODE_LOW = 6;
  localparam int unsigned SC_MULTIPROC = 5;
  localparam int unsigned SC_RX_ENABLE = 4;
  localparam int unsigned SC_TX_NINTH = 3;
  localparam int unsigned SC_RX_NINTH = 2;
  localparam int unsigned SC_TX_DONE = 1;
  localparam int unsigned SC_RX_DONE = 0;

  // Power control bit positions
  localparam int unsigned PC_BAUD_DOUBLE = 7;

  // Config bit positions
  localparam int unsigned CF_RX_TIMER2 = 0;
  localparam int unsigned CF_TX_TIMER2 = 1;
  localparam int unsigned CF_SIX_CLOCK = 2;
  localparam int unsigned CF_IRQ_ENABLE = 3;

  // Reset values
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [3:0] UART_CONFIG_RESET = 4'h0;

  // Serial modes
  localparam logic [1:0] MODE_SYNC = 2'b00;
  localparam logic [1:0] MODE_ASYNC_10 = 2'b01;
  localparam logic [1:0] MODE_ASYNC_FIXED = 2'b10;

  // Timing counts in core clocks
  localparam logic [3:0] M0_PERIOD_TWELVE = 4'hc;
  localparam logic [3:0] M0_PERIOD_SIX = 4'h6;
  localparam logic [2:0] M2_TICK_TWELVE = 3'h4;
  localparam logic [2:0] M2_TICK_SIX = 3'h2;

  // Frame lengths in bit times; last tick, middle tick and last sample counts
  localparam logic [3:0] FRAME_BITS_10 = 4'ha;
  localparam logic [3:0] FRAME_BITS_11 = 4'hb;
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] TICK_MIDDLE = 4'h7;
  localparam logic [3:0] RX_SAMPLES_LAST = 4'h8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : uart_pkg

// >>> rtl/serial_port_control_uart.sv
// How it works
// R1 - Mode bits pick sync, 10-bit or 11-bit frames
// R2 - Mode 0 shifts at oscillator over 12 or 6
// R3 - Mode 2 divides by 64/32, halved when doubled
// R4 - Modes 1,3 use Timer 1 or Timer 2 overflows
// R5 - Baud double affects mode 2 and Timer 1 source
// R6 - Mode 0 ignores the multiprocessor check bit
// R7 - Mode 1 check drops frames with bad stop
// R8 - Modes 2,3 check drops frames with ninth zero
// R9 - Receive enable low refuses all reception; a mode 0 receive already under way still completes
// R10 - Mode 0 receive starts on enable rising
// R11 - Ninth transmit bit sent in modes 2,3 only
// R12 - Ninth receive bit takes ninth or stop bit
// R13 - Transmit done after last bit shifted out
// R14 - Receive done after last sampled frame bit
// R15 - Done flags cleared only by software
// R16 - Interrupt request when enabled and flag set
// R17 - Separate transmit and receive buffer registers
// R18 - Writing data buffer starts a transmission
// R19 - Serial control resets to all zeros
// R20 - Mode 1 frame: start, eight LSB-first, stop
// R21 - Mode 0: data on receive pin, clock out
// R22 - Separate timer select for receive and transmit
// R23 - Load only if done clear and check passes
// R24 - Sixteen ticks per bit, sample mid-bit
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module serial_port_control_uart (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // AXI4-Lite write channels
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read channels
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Baud sources, one-cycle pulses
  input wire logic TIMER1_OVF,
  input wire logic TIMER2_OVF,
  // Serial pins
  input wire logic RXD_IN,
  output logic RXD_OUT,
  output logic RXD_OE,
  output logic TXD_OUT,
  // Interrupt request
  output logic IRQ
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_e;

  // Register index is mapped
  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == uart_pkg::IDX_POWER_CONTROL) || (idx == uart_pkg::IDX_SERIAL_CONTROL) ||
                 (idx == uart_pkg::IDX_SERIAL_DATA_BUFFER) || (idx == uart_pkg::IDX_UART_CONFIG);
  endfunction : idx_mapped

  // Bus state
  logic aw_held_q, w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Software visible state
  logic [1:0] mode_q;
  logic multiproc_check_bit_q, rx_enable_q, tx_ninth_bit_q, rx_ninth_bit_q;
  logic tx_done_flag_q, rx_done_flag_q;
  logic baud_double_bit_q;
  logic [4:0] power_low_q;
  logic [3:0] cfg_q;
  logic [7:0] rx_buf_q, tx_buf_q;

  // Receive pin synchroniser
  logic rxd_m_q, rxd_s_q, rxd_p_q;

  // Write decode
  logic aw_take, w_take, wr_fire, wr_lane;
  logic wr_power, wr_ctrl, wr_data, wr_cfg;
  logic [9:0] wr_idx, rd_idx;
  logic [7:0] wbyte;
  assign aw_take = AWVALID & AWREADY;
  assign w_take = WVALID & WREADY;
  assign wr_fire = aw_held_q & w_held_q & ~BVALID;
  assign wr_idx = aw_addr_q[11:2];
  assign wr_lane = wr_fire & w_strb_q[0];
  assign wbyte = w_data_q[7:0];
  assign wr_power = wr_lane & (wr_idx == uart_pkg::IDX_POWER_CONTROL);
  assign wr_ctrl = wr_lane & (wr_idx == uart_pkg::IDX_SERIAL_CONTROL);
  assign wr_data = wr_lane & (wr_idx == uart_pkg::IDX_SERIAL_DATA_BUFFER); // R17
  assign wr_cfg = wr_lane & (wr_idx == uart_pkg::IDX_UART_CONFIG);

  // Read mux
  logic ar_take;
  logic [7:0] ctrl_val, power_val, rd_byte;
  assign ar_take = ARVALID & ARREADY;
  assign rd_idx = ARADDR[11:2];
  assign ctrl_val = {mode_q, multiproc_check_bit_q, rx_enable_q, tx_ninth_bit_q, rx_ninth_bit_q,
                     tx_done_flag_q, rx_done_flag_q};
  assign power_val = {baud_double_bit_q, 2'b00, power_low_q};
  assign rd_byte = (rd_idx == uart_pkg::IDX_POWER_CONTROL) ? power_val :
                   (rd_idx == uart_pkg::IDX_SERIAL_CONTROL) ? ctrl_val :
                   (rd_idx == uart_pkg::IDX_SERIAL_DATA_BUFFER) ? rx_buf_q : // R17
                   (rd_idx == uart_pkg::IDX_UART_CONFIG) ? {4'h0, cfg_q} : 8'h00;

  // Write channel handshake
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= uart_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= AWADDR;
      end
      if (w_take) begin
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      AWREADY <= ~aw_take & ~aw_held_q & ~BVALID & ~wr_fire;
      WREADY <= ~w_take & ~w_held_q & ~BVALID & ~wr_fire;
      aw_held_q <= (aw_held_q | aw_take) & ~wr_fire;
      w_held_q <= (w_held_q | w_take) & ~wr_fire;
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP <= idx_mapped(wr_idx) ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= uart_pkg::RESP_OKAY;
    end else begin
      ARREADY <= ~ar_take & ~RVALID;
      if (ar_take) begin
        RVALID <= 1'b1;
        RDATA <= {24'h00_0000, rd_byte};
        RRESP <= idx_mapped(rd_idx) ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // Mode and config decode
  logic mode0, mode1, six_clk, baud_dbl;
  assign mode0 = (mode_q == uart_pkg::MODE_SYNC); // R1
  assign mode1 = (mode_q == uart_pkg::MODE_ASYNC_10); // R1
  assign six_clk = cfg_q[uart_pkg::CF_SIX_CLOCK];
  assign baud_dbl = baud_double_bit_q;

  // Baud ticks, sixteen per bit time
  logic [2:0] m2_cnt_q, m2_period;
  logic t1_half_q, m2_tick, t1_tick, rx_tick, tx_tick;
  assign m2_period = (six_clk ? uart_pkg::M2_TICK_SIX : uart_pkg::M2_TICK_TWELVE) >> baud_dbl; // R3 R5
  assign m2_tick = (m2_cnt_q == m2_period - 3'd1);
  assign t1_tick = TIMER1_OVF & (baud_dbl | t1_half_q); // R4 R5
  // Timer 2 path ignores doubling
  assign rx_tick = (mode_q == uart_pkg::MODE_ASYNC_FIXED) ? m2_tick :
                   (cfg_q[uart_pkg::CF_RX_TIMER2] ? TIMER2_OVF : t1_tick); // R4 R22
  assign tx_tick = (mode_q == uart_pkg::MODE_ASYNC_FIXED) ? m2_tick :
                   (cfg_q[uart_pkg::CF_TX_TIMER2] ? TIMER2_OVF : t1_tick); // R4 R22

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      m2_cnt_q <= 3'h0;
      t1_half_q <= 1'b0;
    end else begin
      m2_cnt_q <= m2_tick ? 3'h0 : m2_cnt_q + 3'd1;
      if (TIMER1_OVF) begin
        t1_half_q <= ~t1_half_q;
      end
    end
  end

  // Two flops before the pin is read
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      rxd_p_q <= 1'b1;
    end else begin
      rxd_m_q <= RXD_IN;
      rxd_s_q <= rxd_m_q;
      rxd_p_q <= rxd_s_q;
    end
  end

  // Mode 0 shift engine; clock low in first half of each bit
  logic m0_busy_q, m0_rx_q, ren_prev_q;
  logic [2:0] m0_bit_q;
  logic [3:0] m0_div_q, m0_period, m0_half;
  logic [7:0] m0_data_q;
  logic m0_sample, m0_bit_end, m0_done, m0_rx_start;
  assign m0_period = six_clk ? uart_pkg::M0_PERIOD_SIX : uart_pkg::M0_PERIOD_TWELVE; // R2
  assign m0_half = m0_period >> 1;
  assign m0_sample = m0_busy_q & (m0_div_q == m0_half - 4'd1);
  assign m0_bit_end = m0_busy_q & (m0_div_q == m0_period - 4'd1);
  assign m0_done = m0_bit_end & (m0_bit_q == 3'd7);
  // Needs a fresh rising edge of enable with done clear
  assign m0_rx_start = mode0 & rx_enable_q & ~ren_prev_q & ~rx_done_flag_q & ~m0_busy_q; // R10

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      m0_busy_q <= 1'b0;
      m0_rx_q <= 1'b0;
      m0_bit_q <= 3'h0;
      m0_div_q <= 4'h0;
      m0_data_q <= 8'h00;
      ren_prev_q <= 1'b0;
    end else begin
      ren_prev_q <= rx_enable_q;
      if (wr_data & mode0) begin // R18
        m0_busy_q <= 1'b1;
        m0_rx_q <= 1'b0;
        m0_bit_q <= 3'h0;
        m0_div_q <= 4'h0;
        m0_data_q <= wbyte;
      end else if (m0_rx_start) begin
        m0_busy_q <= 1'b1;
        m0_rx_q <= 1'b1;
        m0_bit_q <= 3'h0;
        m0_div_q <= 4'h0;
      end else if (m0_busy_q) begin
        m0_div_q <= m0_bit_end ? 4'h0 : m0_div_q + 4'd1;
        if (m0_sample & m0_rx_q) begin
          m0_data_q <= {rxd_s_q, m0_data_q[7:1]}; // R21
        end
        if (m0_bit_end) begin
          m0_bit_q <= m0_bit_q + 3'd1;
          if (~m0_rx_q) begin
            m0_data_q <= {1'b1, m0_data_q[7:1]};
          end
          if (m0_done | ~mode0) begin
            m0_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  // Asynchronous transmitter
  logic tx_busy_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q, tx_sub_q;
  logic tx_bit_end, tx_async_done;
  assign tx_bit_end = tx_busy_q & tx_tick & (tx_sub_q == uart_pkg::TICKS_LAST);
  assign tx_async_done = tx_bit_end & (tx_left_q == 4'd1); // R13

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_busy_q <= 1'b0;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_sub_q <= 4'h0;
    end else if (wr_data & ~mode0) begin // R18
      tx_busy_q <= 1'b1;
      tx_sub_q <= 4'h0;
      // Start 0, data LSB first, ninth bit in modes 2,3 only, stop 1
      tx_shift_q <= mode1 ? {2'b11, wbyte, 1'b0} : {1'b1, tx_ninth_bit_q, wbyte, 1'b0}; // R11 R20
      tx_left_q <= mode1 ? uart_pkg::FRAME_BITS_10 : uart_pkg::FRAME_BITS_11; // R1
    end else if (tx_busy_q) begin
      if (tx_tick) begin
        tx_sub_q <= tx_sub_q + 4'd1;
      end
      if (tx_bit_end) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_left_q <= tx_left_q - 4'd1;
        tx_busy_q <= ~tx_async_done;
      end
      if (mode0) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  // Asynchronous receiver
  rx_state_e rx_state_q;
  logic [3:0] rx_sub_q, rx_cnt_q;
  logic [7:0] rx_sr_q;
  logic rx_fall, rx_mid, rx_last, rx_accept, rx_async_set;
  assign rx_fall = rxd_p_q & ~rxd_s_q;
  assign rx_mid = rx_tick & (rx_sub_q == uart_pkg::TICK_MIDDLE); // R24
  assign rx_last = (rx_state_q == RX_DATA) & rx_mid & (rx_cnt_q == uart_pkg::RX_SAMPLES_LAST); // R14
  // Last sample is the stop bit in mode 1, the ninth bit otherwise
  assign rx_accept = ~rx_done_flag_q & (~multiproc_check_bit_q | rxd_s_q); // R7 R8 R23
  assign rx_async_set = rx_last & rx_accept;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rx_state_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sr_q <= 8'h00;
    end else if (~rx_enable_q | mode0) begin // R9
      rx_state_q <= RX_IDLE;
    end else begin
      if (rx_tick) begin
        rx_sub_q <= rx_sub_q + 4'd1;
      end
      unique case (rx_state_q)
        RX_IDLE: begin
          if (rx_fall) begin // R24
            rx_state_q <= RX_START;
            rx_sub_q <= 4'h0;
          end
        end
        RX_START: begin
          // A glitch shorter than half a bit is not a start
          if (rx_mid) begin
            rx_state_q <= rxd_s_q ? RX_IDLE : RX_DATA;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_cnt_q <= rx_cnt_q + 4'd1;
            if (rx_cnt_q != uart_pkg::RX_SAMPLES_LAST) begin
              rx_sr_q <= {rxd_s_q, rx_sr_q[7:1]}; // R20
            end else begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Hardware flag sets; a set in the clearing cycle wins
  logic tx_flag_set, rx_flag_set;
  assign tx_flag_set = (m0_done & ~m0_rx_q) | tx_async_done; // R13
  assign rx_flag_set = (m0_done & m0_rx_q) | rx_async_set; // R6 R14

  // Software registers and buffers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      {mode_q, multiproc_check_bit_q, rx_enable_q, tx_ninth_bit_q, rx_ninth_bit_q,
       tx_done_flag_q, rx_done_flag_q} <= uart_pkg::SERIAL_CONTROL_RESET; // R19
      {baud_double_bit_q, power_low_q} <= {uart_pkg::POWER_CONTROL_RESET[7],
                                            uart_pkg::POWER_CONTROL_RESET[4:0]};
      cfg_q <= uart_pkg::UART_CONFIG_RESET;
      rx_buf_q <= 8'h00;
      tx_buf_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        mode_q <= {wbyte[uart_pkg::SC_MODE_HIGH], wbyte[uart_pkg::SC_MODE_LOW]};
        multiproc_check_bit_q <= wbyte[uart_pkg::SC_MULTIPROC];
        rx_enable_q <= wbyte[uart_pkg::SC_RX_ENABLE];
        tx_ninth_bit_q <= wbyte[uart_pkg::SC_TX_NINTH];
      end
      if (rx_async_set) begin
        rx_ninth_bit_q <= rxd_s_q; // R12
      end else if (wr_ctrl) begin
        rx_ninth_bit_q <= wbyte[uart_pkg::SC_RX_NINTH];
      end
      // Only software clears the done flags
      tx_done_flag_q <= tx_flag_set | (wr_ctrl ? wbyte[uart_pkg::SC_TX_DONE] : tx_done_flag_q); // R15
      rx_done_flag_q <= rx_flag_set | (wr_ctrl ? wbyte[uart_pkg::SC_RX_DONE] : rx_done_flag_q); // R15
      if (wr_power) begin
        baud_double_bit_q <= wbyte[uart_pkg::PC_BAUD_DOUBLE];
        power_low_q <= wbyte[4:0];
      end
      if (wr_cfg) begin
        cfg_q <= wbyte[3:0];
      end
      if (wr_data) begin
        tx_buf_q <= wbyte; // R17
      end
      if (m0_done & m0_rx_q) begin
        rx_buf_q <= m0_data_q; // R6
      end else if (rx_async_set) begin
        rx_buf_q <= rx_sr_q; // R23
      end
    end
  end

  // Pin and interrupt outputs, all registered
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      TXD_OUT <= 1'b1;
      RXD_OUT <= 1'b1;
      RXD_OE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      TXD_OUT <= mode0 ? ~(m0_busy_q & (m0_div_q < m0_half)) : (~tx_busy_q | tx_shift_q[0]); // R21
      RXD_OUT <= m0_data_q[0];
      RXD_OE <= mode0 & m0_busy_q & ~m0_rx_q; // R21
      IRQ <= cfg_q[uart_pkg::CF_IRQ_ENABLE] & (tx_done_flag_q | rx_done_flag_q); // R16
    end
  end

endmodule : serial_port_control_uart

// >>> test/serial_port_control_uart_properties.sv
`timescale 1ns/1ps
module serial_port_control_uart_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  // Pins and request
  input wire logic TXD_OUT,
  input wire logic RXD_OE,
  input wire logic IRQ
);
  // One domain, so clock and reset are named once
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  // Quiet outputs on the first cycle out of reset
  property p_reset_idle;
    $fell(SRST) |-> !AWREADY && !ARREADY && !BVALID && !RVALID && TXD_OUT && !RXD_OE && !IRQ;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");

  // Write answer stands until taken
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

  // Read answer stands until taken
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

  // Registers are one byte wide, upper lanes stay zero
  property p_r_byte;
    RVALID |-> RDATA[31:8] == 24'h00_0000;
  endproperty
  a_r_byte: assert property (p_r_byte) else $error("upper read lanes not zero");

  // Response follows a joint address and data take
  property p_w_ans;
    AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write response missing");

  // Read answer next cycle, no second address meanwhile
  property p_r_ans;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer missing");

  // Flags only fall through a software write
  property p_irq_fall;
    $fell(IRQ) |-> BVALID || $past(BVALID) || $past(BVALID, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without a write");

  // Sync transmit drives the data pin for at least eight clocks after it starts
  property p_oe_span;
    $rose(RXD_OE) |-> RXD_OE [*8];
  endproperty
  a_oe_span: assert property (p_oe_span) else $error("data pin released mid byte");
endmodule : serial_port_control_uart_chk

bind serial_port_control_uart serial_port_control_uart_chk chk (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .TXD_OUT(TXD_OUT),
  .RXD_OE(RXD_OE), .IRQ(IRQ)
);

// >>> test/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic clk,
  // Pins as the far device sees them
  input wire logic txd,
  input wire logic rxd_oe,
  input wire logic rxd_out,
  output logic rxd_drv
);
  int bit_clks = 64;
  int nbits = 10;
  int got = 0;
  logic [10:0] cap = 11'h000;
  logic m0_on = 1'b0;
  logic line = 1'b1;
  logic [7:0] m0_tx = 8'h00;
  logic [7:0] m0_rx = 8'h00;

  // Idle line is high; sync mode offers the next bit of its byte
  assign rxd_drv = m0_on ? m0_tx[0] : line;

  // Sync slave: bits move on the rising shift clock, far from sampling
  always @(posedge txd) begin
    if (m0_on && rxd_oe)
      m0_rx <= {rxd_out, m0_rx[7:1]};
    else if (m0_on)
      m0_tx <= {1'b1, m0_tx[7:1]};
  end

  // Async listener: start edge, then one sample mid-bit
  initial begin
    forever begin
      @(negedge txd);
      if (!m0_on) begin
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
          cap[i] = txd;
          repeat (bit_clks) @(posedge clk);
        end
        got++;
      end
    end
  end

  // One idle bit first so back-to-back frames still show a start edge
  task automatic send(input logic [10:0] bits, input int n);
    line <= 1'b1;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    line <= 1'b1;
  endtask : send
endmodule : serial_peer

// >>> test/serial_port_control_uart_tb_top.sv
`timescale 1ns/1ps
module serial_port_control_uart_tb_top;
  localparam logic [9:0] SC = uart_pkg::IDX_SERIAL_CONTROL;
  localparam logic [9:0] SB = uart_pkg::IDX_SERIAL_DATA_BUFFER;
  localparam logic [9:0] PC = uart_pkg::IDX_POWER_CONTROL;
  localparam logic [9:0] CF = uart_pkg::IDX_UART_CONFIG;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic t1 = 1'b0, t2 = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd_oe, rxd_out, txd, irq, rxd_drv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire logic rxd_pin;
  int cyc = 0, fails = 0, checks = 0;

  // Shared data pin: whoever enables drives it
  assign rxd_pin = rxd_oe ? rxd_out : rxd_drv;

  serial_port_control_uart DUT (
    .CORE_CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .TIMER1_OVF(t1),
    .TIMER2_OVF(t2), .RXD_IN(rxd_pin), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD_OUT(txd), .IRQ(irq)
  );

  serial_peer peer (.clk(clk), .txd(txd), .rxd_oe(rxd_oe), .rxd_out(rxd_out), .rxd_drv(rxd_drv));

  initial forever #50 clk = ~clk;

  // Overflow pulses: Timer 1 every 2 clocks, Timer 2 every 3; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    t1 <= cyc[0];
    t2 <= (cyc % 3) == 0;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, want);
    end
  endtask : chk

  // Ready is looked at mid-cycle, so the decision lands on the taking edge
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] rsp = uart_pkg::RESP_OKAY);
    logic a, w, b;
    {a, w, b} = 3'b111;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    {awvalid, wvalid, bready} <= 3'b111;
    while (b) begin
      @(negedge clk);
      if (bvalid)
        chk({8'h00, bresp}, {8'h00, rsp});
      a = a && !awready;
      w = w && !wready;
      b = !bvalid;
      @(posedge clk);
      {awvalid, wvalid, bready} <= {a, w, b};
    end
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [9:0] want, input logic [9:0] m = 10'h3ff);
    logic a, r;
    {a, r} = 2'b11;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    while (r) begin
      @(negedge clk);
      if (rvalid)
        chk({rresp, rdata[7:0]} & m, want);
      a = a && !arready;
      r = !rvalid;
      @(posedge clk);
      {arvalid, rready} <= {a, r};
    end
  endtask : rdc

  task automatic complete_run;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Main sequence: registers, then each mode from the far side
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdc(SC, 10'h000);
    rdc(PC, 10'h000);
    rdc(10'h3ff, {uart_pkg::RESP_SLVERR, 8'h00}, 10'h300);
    wr(10'h3ff, 8'hFF, uart_pkg::RESP_SLVERR);
    wr(CF, 8'h08);
    wr(SC, 8'h50);
    wr(SB, 8'hA5);
    wait (peer.got == 1);
    chk(peer.cap[9:0], {1'b1, 8'hA5, 1'b0});
    rdc(SC, 10'h052);
    chk({9'h000, irq}, 10'h001);
    wr(SC, 8'h50);
    repeat (2) @(posedge clk);
    chk({9'h000, irq}, 10'h000);
    wr(SC, 8'h60);
    peer.send({2'b01, 8'h22, 1'b0}, 10);
    rdc(SC, 10'h060);
    wr(SC, 8'h70);
    peer.send({2'b00, 8'h33, 1'b0}, 10);
    rdc(SC, 10'h070);
    peer.send({2'b01, 8'h96, 1'b0}, 10);
    rdc(SC, 10'h075);
    peer.send({2'b01, 8'h11, 1'b0}, 10);
    rdc(SB, 10'h096);
    peer.bit_clks = 48;
    peer.nbits = 11;
    wr(CF, 8'h0A);
    wr(SC, 8'hC8);
    wr(SB, 8'h3C);
    wait (peer.got == 2);
    chk(peer.cap[10:1], {1'b1, 1'b1, 8'h3C});
    peer.bit_clks = 32;
    wr(PC, 8'h80);
    wr(SC, 8'hB0);
    peer.send({2'b10, 8'h77, 1'b0}, 11);
    rdc(SC, 10'h0B0);
    peer.send({2'b11, 8'h5A, 1'b0}, 11);
    rdc(SC, 10'h0B5);
    rdc(SB, 10'h05A);
    peer.m0_on <= 1'b1;
    wr(SC, 8'h00);
    wr(SB, 8'hC3);
    repeat (150) @(posedge clk);
    chk({2'b00, peer.m0_rx}, 10'h0C3);
    rdc(SC, 10'h002);
    peer.m0_tx <= 8'h6E;
    wr(SC, 8'h30);
    repeat (150) @(posedge clk);
    rdc(SC, 10'h031);
    rdc(SB, 10'h06E);
    wr(CF, 8'h04);
    wr(SC, 8'h00);
    wr(SB, 8'h81);
    repeat (70) @(posedge clk);
    rdc(SC, 10'h002);
    chk({2'b00, peer.m0_rx}, 10'h081);
    // Mid-run reset must wipe flags, mode and doubling
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdc(SC, 10'h000);
    rdc(PC, 10'h000);
    complete_run();
  end
endmodule : serial_port_control_uart_tb_top
